// ===== inc/stwr_pkg.sv
`default_nettype none

package stwr_pkg;

    // ----------------------------------------
    // Instruction framing
    // ----------------------------------------
    localparam int STWR_START_LEN = 3;
    localparam int STWR_SETUP_LEN = 4;
    localparam int STWR_STOP_LEN = 3;
    localparam int STWR_FRAME_LEN = STWR_START_LEN + STWR_SETUP_LEN + STWR_STOP_LEN;
    localparam logic [2:0] STWR_START_FIELD = 3'h7;
    localparam logic [2:0] STWR_STOP_FIELD = 3'h0;

    // Setup codes, one per instruction
    localparam logic [3:0] STWR_SETUP_PRESSURE = 4'hA;
    localparam logic [3:0] STWR_SETUP_TEMPERATURE = 4'h9;
    localparam logic [3:0] STWR_SETUP_CAL0 = 4'h5;
    localparam logic [3:0] STWR_SETUP_CAL1 = 4'h6;
    localparam logic [3:0] STWR_SETUP_CAL2 = 4'h3;
    localparam logic [3:0] STWR_SETUP_CAL3 = 4'hC;

    // Resynchronising pattern, newest bit in bit 0
    localparam int STWR_RESET_LEN = 21;
    localparam logic [20:0] STWR_RESET_PATTERN = 21'h15_5540;

    // ----------------------------------------
    // Readout and handshake counts
    // ----------------------------------------
    localparam int STWR_WORD_LEN = 16;
    localparam int STWR_READ_CLOCKS = 17;
    localparam int STWR_ACK_CLOCKS = 2;
    localparam int STWR_CAL_WORDS = 4;
    localparam int STWR_CAL_BITS = 64;

    // Calibration content, arbitrary values
    localparam logic [63:0] STWR_CAL_DATA = 64'h4444_3333_2222_1111;

    // ----------------------------------------
    // Conversion timing on the master clock
    // ----------------------------------------
    localparam longint STWR_CONV_TIME_US = 35000;
    localparam longint STWR_MCLK_HZ = 32768;
    localparam int STWR_CONV_MCLK_CYCLES =
        int'((STWR_CONV_TIME_US * STWR_MCLK_HZ) / 64'd1000000);

    // Interface states
    typedef enum logic [2:0] {
        STWR_ST_IDLE,
        STWR_ST_ACK,
        STWR_ST_CONV,
        STWR_ST_READ
    } stwr_state_type;

endpackage

`default_nettype wire

// ===== src/stwr_buf.sv
`timescale 1ns/1ps
`default_nettype none

// Small FIFO between conversion and readout
module stwr_buf
    import stwr_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } stwr_buf_state_type;

    stwr_buf_state_type st_r;
    stwr_buf_state_type st_nxt;
    logic push;
    logic pop;

    // Honest flags from the fill count
    assign in_ready = (st_r.count != CW'(DEPTH));
    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wr] = in_data;
            st_nxt.wr = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
        end
        st_nxt.count = st_r.count + CW'(push) - CW'(pop);
        if (flush)
        begin
            st_nxt.wr = '0;
            st_nxt.rd = '0;
            st_nxt.count = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule

`default_nettype wire

// ===== src/stwr_conv.sv
`timescale 1ns/1ps
`default_nettype none

// Conversion timer paced by the master clock pin
module stwr_conv
    import stwr_pkg::*;
#(
    parameter int CONV_CYCLES = STWR_CONV_MCLK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic mclk,
    input wire logic start,
    input wire logic use_temp,
    input wire logic abort,
    input wire logic [15:0] pressure_sample,
    input wire logic [15:0] temperature_sample,
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_data
);
    localparam int CW = $clog2(CONV_CYCLES + 1);

    typedef struct packed {
        logic mclk_s1;
        logic mclk_s2;
        logic mclk_s3;
        logic busy;
        logic temp;
        logic [CW-1:0] cnt;
        logic valid;
        logic [15:0] data;
    } stwr_conv_state_type;

    stwr_conv_state_type st_r;
    stwr_conv_state_type st_nxt;
    logic mclk_rise;

    assign mclk_rise = st_r.mclk_s2 & ~st_r.mclk_s3;
    assign out_valid = st_r.valid;
    assign out_data = st_r.data;

    // Count master clock edges, stall while result is unread
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.mclk_s1 = mclk;
        st_nxt.mclk_s2 = st_r.mclk_s1;
        st_nxt.mclk_s3 = st_r.mclk_s2;
        if (st_r.valid && out_ready)
            st_nxt.valid = 1'b0;
        if (start)
        begin
            st_nxt.busy = 1'b1;
            st_nxt.temp = use_temp;
            st_nxt.cnt = '0;
        end
        else if (st_r.busy && st_r.cnt == CW'(CONV_CYCLES))
        begin
            if (!st_nxt.valid)
            begin
                st_nxt.busy = 1'b0;
                st_nxt.valid = 1'b1;
                st_nxt.data = st_r.temp ? temperature_sample : pressure_sample;
            end
        end
        else if (st_r.busy && mclk_rise)
            st_nxt.cnt = st_r.cnt + 1'b1;
        if (abort)
        begin
            st_nxt.busy = 1'b0;
            st_nxt.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule

`default_nettype wire

// ===== src/stwr_readout.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Three-wire sensor readout, device end
// ----------------------------------------

module stwr_readout
    import stwr_pkg::*;
#(
    parameter int CONV_CYCLES = STWR_CONV_MCLK_CYCLES,
    parameter logic [63:0] CAL_DATA = STWR_CAL_DATA,
    // Result queue depth; two covers one result in flight
    parameter int BUF_DEPTH = 2
)
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Host link pins
    input wire logic sclk,
    input wire logic din,
    // Conversion master clock pin
    input wire logic mclk,
    // Front-end results, same clock domain
    input wire logic [15:0] pressure_sample,
    input wire logic [15:0] temperature_sample,
    // Data and status to the host
    output logic dout
);

    // ----------------------------------------
    // State record
    // ----------------------------------------

    // All registered state of the interface
    typedef struct packed {
        // Pin synchronisers and edge stage
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic din_s1;
        logic din_s2;
        // Bit history and sequencing
        logic [STWR_RESET_LEN-1:0] hist;
        stwr_state_type state;
        logic [4:0] cnt;
        logic [15:0] shreg;
        // Output and strobes to the engine
        logic dout;
        logic conv_start;
        logic conv_temp;
        logic abort;
    } stwr_main_type;

    // Current and next copy of the record
    stwr_main_type st_r;
    stwr_main_type st_nxt;

    // Edge and framing views of the synchronised pins
    logic sclk_rise;
    logic [STWR_RESET_LEN-1:0] hist_new;
    logic [3:0] setup;
    logic frame_ok;

    // Conversion path handshake
    logic conv_valid;
    logic conv_ready;
    logic [15:0] conv_data;
    logic res_valid;
    logic res_ready;
    logic [15:0] res_data;

    // ----------------------------------------
    // Calibration store
    // ----------------------------------------

    // Four words cut from the calibration image
    // Word zero sits in the lowest sixteen bits
    logic [15:0] cal_word [STWR_CAL_WORDS];

    // One continuous assignment per word
    genvar gi;
    generate
        for (gi = 0; gi < STWR_CAL_WORDS; gi++)
        begin : g_cal
            assign cal_word[gi] = CAL_DATA[gi*STWR_WORD_LEN +: STWR_WORD_LEN];
        end
    endgenerate

    // ----------------------------------------
    // Conversion engine and result buffer
    // ----------------------------------------

    // Timed conversion on the master clock
    // Abort comes from the reset pattern; a pin reset clears it as well
    // Engine stalls with its result held while the queue is full
    stwr_conv #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk(clk),
        .rst_b(rst_b),
        .mclk(mclk),
        .start(st_r.conv_start),
        .use_temp(st_r.conv_temp),
        .abort(st_r.abort),
        .pressure_sample(pressure_sample),
        .temperature_sample(temperature_sample),
        .out_valid(conv_valid),
        .out_ready(conv_ready),
        .out_data(conv_data)
    );

    // Result waits here until the readout takes it
    // Flushed with the engine so no stale word survives a resync
    stwr_buf #(
        .WIDTH(STWR_WORD_LEN),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .flush(st_r.abort),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_data),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    // Only a waiting conversion drains the buffer
    // A result arriving in any other state stays queued
    assign res_ready = (st_r.state == STWR_ST_CONV);

    // ----------------------------------------
    // Pin views
    // ----------------------------------------

    // Rising shift-clock edge after the synchronisers
    // Each shift-clock level must last at least one clock to be seen
    assign sclk_rise = st_r.sclk_s2 & ~st_r.sclk_s3;

    // History with the bit taken at this edge
    // Input bit read at the same synchroniser depth as the clock
    assign hist_new = {st_r.hist[STWR_RESET_LEN-2:0], st_r.din_s2};

    // Frame fields, newest bit at the bottom
    // Last ten bits: start on top, setup in the middle, stop below
    assign setup = hist_new[STWR_STOP_LEN +: STWR_SETUP_LEN];
    assign frame_ok =
        (hist_new[STWR_FRAME_LEN-1 -: STWR_START_LEN] == STWR_START_FIELD) &&
        (hist_new[STWR_STOP_LEN-1:0] == STWR_STOP_FIELD);

    // ----------------------------------------
    // Interface sequencing
    // ----------------------------------------

    // Next state of the whole interface
    // Engine strobes last one clock; all else holds unless changed
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sclk_s1 = sclk;
        st_nxt.sclk_s2 = st_r.sclk_s1;
        st_nxt.sclk_s3 = st_r.sclk_s2;
        st_nxt.din_s1 = din;
        st_nxt.din_s2 = st_r.din_s1;
        st_nxt.conv_start = 1'b0;
        st_nxt.abort = 1'b0;

        // Finished conversion: load result and drop the line
        // A coincident edge in the wait state keeps this load
        if (st_r.state == STWR_ST_CONV && res_valid)
        begin
            st_nxt.shreg = res_data;
            st_nxt.cnt = '0;
            st_nxt.dout = 1'b0;
            st_nxt.state = STWR_ST_READ;
        end

        // Shifting and framing done only at shift-clock edges; an idle clock holds all but the result load above
        // Pauses in a readout therefore cost nothing but time
        if (sclk_rise)
        begin
            // History fills in every state; the line may move meanwhile
            st_nxt.hist = hist_new;
            case (st_r.state)
                STWR_ST_IDLE:
                begin
                    // Frame recognised purely from the bit stream
                    // Unknown setup codes fall through and leave the block idle
                    if (frame_ok)
                    begin
                        st_nxt.cnt = '0;
                        case (setup)
                            // Conversions: raise the line as acknowledge
                            STWR_SETUP_PRESSURE:
                            begin
                                st_nxt.conv_temp = 1'b0;
                                st_nxt.dout = 1'b1;
                                st_nxt.state = STWR_ST_ACK;
                            end
                            STWR_SETUP_TEMPERATURE:
                            begin
                                st_nxt.conv_temp = 1'b1;
                                st_nxt.dout = 1'b1;
                                st_nxt.state = STWR_ST_ACK;
                            end
                            // Calibration words: load, wait for the first clock
                            STWR_SETUP_CAL0:
                            begin
                                st_nxt.shreg = cal_word[0];
                                st_nxt.state = STWR_ST_READ;
                            end
                            STWR_SETUP_CAL1:
                            begin
                                st_nxt.shreg = cal_word[1];
                                st_nxt.state = STWR_ST_READ;
                            end
                            STWR_SETUP_CAL2:
                            begin
                                st_nxt.shreg = cal_word[2];
                                st_nxt.state = STWR_ST_READ;
                            end
                            STWR_SETUP_CAL3:
                            begin
                                st_nxt.shreg = cal_word[3];
                                st_nxt.state = STWR_ST_READ;
                            end
                            // Unknown code: frame dropped
                            default:
                            begin
                                st_nxt.state = STWR_ST_IDLE;
                            end
                        endcase
                        // Fresh history so the next frame needs all ten bits
                        st_nxt.hist = '0;
                    end
                end
                STWR_ST_ACK:
                begin
                    // Line stays high over the two trailing clocks
                    // Engine starts on the second one
                    st_nxt.cnt = st_r.cnt + 5'd1;
                    if (st_r.cnt == 5'(STWR_ACK_CLOCKS - 1))
                    begin
                        st_nxt.conv_start = 1'b1;
                        st_nxt.state = STWR_ST_CONV;
                    end
                end
                STWR_ST_CONV:
                begin
                    // Host keeps the clock low; nothing to shift
                    // Stray edges only feed the history for the reset pattern
                    // Never undo a result load made in this same clock
                    if (!res_valid)
                        st_nxt.state = STWR_ST_CONV;
                end
                STWR_ST_READ:
                begin
                    // Sixteen data edges, then one closing edge
                    // Closing edge parks the line low and frees the interface
                    if (st_r.cnt < 5'(STWR_WORD_LEN))
                    begin
                        st_nxt.dout = st_r.shreg[STWR_WORD_LEN-1];
                        st_nxt.shreg = {st_r.shreg[STWR_WORD_LEN-2:0], 1'b0};
                        st_nxt.cnt = st_r.cnt + 5'd1;
                    end
                    else
                    begin
                        // Seventeenth edge
                        st_nxt.dout = 1'b0;
                        st_nxt.cnt = '0;
                        st_nxt.state = STWR_ST_IDLE;
                    end
                end
                default:
                begin
                    st_nxt.state = STWR_ST_IDLE;
                end
            endcase

            // Full reset pattern wins over anything in progress
            // Also drops any queued or running conversion
            // Matched on every edge, even inside a readout
            if (hist_new == STWR_RESET_PATTERN)
            begin
                st_nxt.state = STWR_ST_IDLE;
                st_nxt.dout = 1'b0;
                st_nxt.cnt = '0;
                st_nxt.hist = '0;
                st_nxt.abort = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------

    // Single register bank for all interface state
    // Reset value keeps the output low and the history empty
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Status and data share one pin
    // Driven straight from its flip-flop, no glitch between states
    assign dout = st_r.dout;

endmodule

`default_nettype wire

// ===== verification/stwr_readout_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Link checker
// ----------------------------------------
module stwr_readout_chk
    import stwr_pkg::*;
#(
    parameter logic [63:0] CAL_DATA = STWR_CAL_DATA
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout
);
    logic [2:0] sc_r;
    logic [1:0] dn_r;
    logic [3:0] since_r;
    logic [20:0] hist_r;
    logic [20:0] hist_nxt;
    logic msb_r;
    logic rise;
    logic frame;
    logic conv_hit;
    logic cal_hit;
    logic [1:0] idx;

    // Rise seen after the same two-stage sync as the block
    always_comb
    begin
        rise = sc_r[1] & ~sc_r[2];
        hist_nxt = {hist_r[19:0], dn_r[1]};
        frame = rise && hist_nxt[9:7] == STWR_START_FIELD && hist_nxt[2:0] == STWR_STOP_FIELD;
        conv_hit = frame && hist_nxt[6:3] inside {STWR_SETUP_PRESSURE, STWR_SETUP_TEMPERATURE};
        cal_hit = frame && hist_nxt[6:3] inside {STWR_SETUP_CAL0, STWR_SETUP_CAL1,
            STWR_SETUP_CAL2, STWR_SETUP_CAL3};
        idx = (hist_nxt[6:3] == STWR_SETUP_CAL1) ? 2'h1 :
            (hist_nxt[6:3] == STWR_SETUP_CAL2) ? 2'h2 :
            (hist_nxt[6:3] == STWR_SETUP_CAL3) ? 2'h3 : 2'h0;
    end

    // Pin age since the last rise, bit history, expected first bit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sc_r <= 3'h0;
            dn_r <= 2'h0;
            since_r <= 4'hF;
            hist_r <= 21'h00_0000;
            msb_r <= 1'h0;
        end
        else
        begin
            sc_r <= {sc_r[1:0], sclk};
            dn_r <= {dn_r[0], din};
            since_r <= (sclk && !sc_r[0]) ? 4'h1 : since_r + {3'h0, since_r != 4'hF};
            if (rise)
                hist_r <= (conv_hit || cal_hit) ? 21'h00_0000 : hist_nxt;
            if (cal_hit)
                msb_r <= CAL_DATA[idx * 16 + 15];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_ack_rise;
        ##[1:4] dout;
    endsequence
    sequence s_ack_hold;
        dout [*6];
    endsequence
    property p_first_low;
        $rose(rst_b) |-> !dout;
    endproperty
    property p_launch;
        $changed(dout) |-> since_r inside {[4'h1:4'h6]} || !sclk;
    endproperty
    property p_conv_ack;
        conv_hit |-> s_ack_rise ##1 s_ack_hold;
    endproperty
    property p_conv_end;
        $fell(dout) && since_r > 4'h6 |=> !dout [*3];
    endproperty
    property p_idle_hold;
        !sclk && since_r > 4'h6 && !dout |=> !dout;
    endproperty
    property p_cal_quiet;
        cal_hit |=> !dout [*6];
    endproperty
    property p_cal_msb;
        cal_hit |-> ##13 dout == msb_r;
    endproperty
    property p_resync;
        rise && hist_nxt == STWR_RESET_PATTERN |-> ##5 !dout;
    endproperty

    a_first_low: assert property (p_first_low) else $error("dout high after reset");
    a_launch: assert property (p_launch) else $error("dout moved off a rise");
    a_conv_ack: assert property (p_conv_ack) else $error("no conversion ack");
    a_conv_end: assert property (p_conv_end) else $error("end flag glitch");
    a_idle_hold: assert property (p_idle_hold) else $error("dout rose while idle");
    a_cal_quiet: assert property (p_cal_quiet) else $error("cal read acked");
    a_cal_msb: assert property (p_cal_msb) else $error("cal first bit wrong");
    a_resync: assert property (p_resync) else $error("reset pattern ignored");
endmodule

bind stwr_readout stwr_readout_chk #(.CAL_DATA(CAL_DATA)) u_stwr_readout_chk (
    .clk(clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .din(din),
    .dout(dout)
);

`default_nettype wire

// ===== verification/stwr_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host side of the link
// ----------------------------------------
module stwr_host
    import stwr_pkg::*;
(
    input wire logic clk,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    // Shift clock parked low at start
    initial
    begin
        sclk = 1'h0;
        din = 1'h0;
    end

    // One shift clock, 320 ns; dout taken while it still stands
    task automatic xfer(input logic b, output logic q);
        sclk <= 1'h0;
        din <= b;
        repeat (4) @(posedge clk);
        q = dout;
        sclk <= 1'h1;
        repeat (4) @(posedge clk);
    endtask

    task automatic park(input int n);
        sclk <= 1'h0;
        repeat (n) @(posedge clk);
    endtask

    // Start, setup and stop fields, MSB first
    task automatic send_frame(input logic [3:0] code);
        logic [9:0] f;
        logic q;
        f = {STWR_START_FIELD, code, STWR_STOP_FIELD};
        for (int i = 9; i >= 0; i--)
            xfer(f[i], q);
    endtask

    // Output is not looked at during the pattern
    task automatic send_reset();
        logic q;
        for (int i = STWR_RESET_LEN - 1; i >= 0; i--)
            xfer(STWR_RESET_PATTERN[i], q);
    endtask

    // Seventeen clocks, optional pause before bit pause_at
    task automatic read_word(input int pause_at, output logic lead, output logic [15:0] w);
        logic q;
        xfer(1'h0, lead);
        for (int i = 15; i >= 0; i--)
        begin
            if (i == pause_at)
                park(100);
            xfer(1'h0, q);
            w[i] = q;
        end
        park(8);
    endtask

    // Frame, two ack clocks, clock held low until the end flag
    task automatic convert(input logic [3:0] code, input int pause_at, output logic [1:0] ack,
        output logic done, output logic lead, output logic [15:0] w);
        send_frame(code);
        xfer(1'h0, ack[1]);
        xfer(1'h0, ack[0]);
        park(4);
        done = 1'h0;
        for (int i = 0; i < 20000 && !done; i++)
        begin
            @(posedge clk);
            done = (dout === 1'h0);
        end
        if (done)
            read_word(pause_at, lead, w);
    endtask
endmodule

`default_nettype wire

// ===== verification/tb_stwr_readout.sv
`timescale 1ns/1ps
`default_nettype none

`define STWR_CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end

// ----------------------------------------
// Readout testbench
// ----------------------------------------
module tb_stwr_readout
    import stwr_pkg::*;
;
    localparam logic [3:0] CAL_CODE [4] = '{STWR_SETUP_CAL0, STWR_SETUP_CAL1,
        STWR_SETUP_CAL2, STWR_SETUP_CAL3};
    // Test image: every word has its top bit set so the first bit shows
    localparam logic [63:0] CAL_IMAGE = 64'hB00C_9F01_E5A7_8421;
    logic clk;
    logic rst_b;
    logic mclk;
    logic sclk;
    logic din;
    logic dout;
    logic [15:0] pressure_sample;
    logic [15:0] temperature_sample;
    int fail_count;
    int check_count;

    stwr_readout #(.CONV_CYCLES(4), .CAL_DATA(CAL_IMAGE)) u_stwr_readout (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .din(din),
        .mclk(mclk),
        .pressure_sample(pressure_sample),
        .temperature_sample(temperature_sample),
        .dout(dout)
    );

    stwr_host u_stwr_host (
        .clk(clk),
        .sclk(sclk),
        .din(din),
        .dout(dout)
    );

    // 25 MHz system clock, slower master clock
    initial
        clk = 1'h0;
    always #20 clk = ~clk;
    always
    begin
        repeat (40) @(posedge clk);
        mclk <= ~mclk;
    end

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic t_reset_idle();
        `STWR_CHK(dout, 1'h0)
        u_stwr_host.send_reset();
        u_stwr_host.park(8);
        `STWR_CHK(dout, 1'h0)
    endtask

    task automatic t_cal(input int k);
        logic lead;
        logic [15:0] w;
        u_stwr_host.send_frame(CAL_CODE[k]);
        u_stwr_host.read_word(-1, lead, w);
        `STWR_CHK(lead, 1'h0)
        `STWR_CHK(w, CAL_IMAGE[16 * k +: 16])
        `STWR_CHK(dout, 1'h0)
    endtask

    // Other sample set to the inverse so a wrong pick shows
    task automatic t_conv(input logic temp, input logic [15:0] val, input int pause_at);
        logic [1:0] ack;
        logic done;
        logic lead;
        logic [15:0] w;
        pressure_sample <= temp ? ~val : val;
        temperature_sample <= temp ? val : ~val;
        u_stwr_host.convert(temp ? STWR_SETUP_TEMPERATURE : STWR_SETUP_PRESSURE, pause_at,
            ack, done, lead, w);
        `STWR_CHK(ack, 2'h3)
        `STWR_CHK(done, 1'h1)
        if (done !== 1'h1)
            finish_test();
        `STWR_CHK(lead, 1'h0)
        `STWR_CHK(w, val)
        `STWR_CHK(dout, 1'h0)
    endtask

    task automatic t_bad_code();
        logic q;
        u_stwr_host.send_frame(4'hF);
        u_stwr_host.xfer(1'h0, q);
        u_stwr_host.park(8);
        `STWR_CHK(q, 1'h0)
        `STWR_CHK(dout, 1'h0)
    endtask

    // Reset pattern cuts a conversion; its result never appears
    task automatic t_resync();
        logic [1:0] ack;
        pressure_sample <= 16'h1234;
        u_stwr_host.send_frame(STWR_SETUP_PRESSURE);
        u_stwr_host.xfer(1'h0, ack[1]);
        u_stwr_host.xfer(1'h0, ack[0]);
        u_stwr_host.send_reset();
        u_stwr_host.park(8);
        `STWR_CHK(ack, 2'h3)
        `STWR_CHK(dout, 1'h0)
        u_stwr_host.park(600);
        `STWR_CHK(dout, 1'h0)
        t_conv(1'h1, 16'h0FF0, -1);
    endtask

    // Pin reset in mid-conversion: line low, no late result, link usable
    task automatic t_hard_reset();
        logic [1:0] ack;
        u_stwr_host.send_frame(STWR_SETUP_PRESSURE);
        u_stwr_host.xfer(1'h0, ack[1]);
        u_stwr_host.xfer(1'h0, ack[0]);
        u_stwr_host.park(20);
        `STWR_CHK(ack, 2'h3)
        `STWR_CHK(dout, 1'h1)
        rst_b <= 1'h0;
        repeat (3) @(posedge clk);
        `STWR_CHK(dout, 1'h0)
        rst_b <= 1'h1;
        u_stwr_host.park(600);
        `STWR_CHK(dout, 1'h0)
        t_cal(1);
    endtask

    // Main sequence
    initial
    begin
        rst_b = 1'h0;
        mclk = 1'h0;
        pressure_sample = 16'h0000;
        temperature_sample = 16'h0000;
        fail_count = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        t_reset_idle();
        for (int k = 0; k < 4; k++)
            t_cal(k);
        t_conv(1'h0, 16'hA5C3, 8);
        t_conv(1'h1, 16'h3C5A, -1);
        t_bad_code();
        t_cal(3);
        t_resync();
        t_hard_reset();
        finish_test();
    end
endmodule

`default_nettype wire
